// ===== logic/peripheral_irq_enable_bank.sv
// peripheral interrupt enable bank with apb register slave
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps

// Behaviour
// - peripheral enables need gate bit set
// - first-level sources bypass the peripheral gate
// - adc enable at bit 0 register one
// - external interrupt pin chosen by selector
// - comparator one enable at bit 0, two
// - vector when flag, enable, global set
module peripheral_irq_enable_bank (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sources
  input wire irq_bank_pkg::periph_src_t periph_src,
  input wire logic [irq_bank_pkg::NUM_PINS-1:0] ext_pins,
  // cpu side
  output logic vector_req,
  output logic irq
);
  import irq_bank_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] first_r, first_nxt;
  logic [7:0] pen_one_r, pen_one_nxt;
  logic [7:0] pen_two_r, pen_two_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [2:0] ext_irq_pin_select_r, pinsel_nxt;
  logic [7:0] stat_r, stat_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic [NUM_PINS-1:0] pin_s1_r, pin_s2_r;
  logic ext_prev_r;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt, vector_nxt, irq_nxt;
  logic ext_level, ext_rise, wr_acc, rd_acc, hit, gated_periph, gated_first;
  logic [7:0] set_flags;

  // byte-wide masked write for writable fields
  function automatic logic [7:0] wr8(input logic [7:0] old, input logic [7:0] d,
                                     input logic [7:0] m);
    wr8 = (old & ~m) | (d & m);
  endfunction

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  // pins arrive from outside; only the second stage is looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      ext_prev_r <= 1'b0;
    end else begin
      pin_s1_r <= ext_pins;
      pin_s2_r <= pin_s1_r;
      ext_prev_r <= ext_level;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    ext_level = pin_s2_r[ext_irq_pin_select_r];
    ext_rise = ext_level & ~ext_prev_r;
    wr_acc = psel & penable & pwrite & pready;
    rd_acc = psel & ~penable & ~pwrite;
    hit = (paddr == ADDR_CTRL) || (paddr == ADDR_FIRST) || (paddr == ADDR_PEN_ONE) ||
          (paddr == ADDR_PEN_TWO) || (paddr == ADDR_FLAGS) || (paddr == ADDR_PINSEL) ||
          (paddr == ADDR_STAT) || (paddr == ADDR_MASK);
    set_flags = {1'b0, periph_src.cmp_two, periph_src.cmp_one, periph_src.zero_cross,
                 periph_src.adc, periph_src.clk_switch, periph_src.osc_fail, ext_rise};
    ctrl_nxt = ctrl_r;
    first_nxt = first_r;
    pen_one_nxt = pen_one_r;
    pen_two_nxt = pen_two_r;
    flags_nxt = flags_r;
    pinsel_nxt = ext_irq_pin_select_r;
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    if (wr_acc) begin
      unique case (paddr)
        ADDR_CTRL: ctrl_nxt = wr8(ctrl_r, pwdata[7:0], CTRL_WMASK);
        ADDR_FIRST: first_nxt = wr8(first_r, pwdata[7:0], FIRST_WMASK);
        ADDR_PEN_ONE: pen_one_nxt = wr8(pen_one_r, pwdata[7:0], ONE_WMASK);
        ADDR_PEN_TWO: pen_two_nxt = wr8(pen_two_r, pwdata[7:0], TWO_WMASK);
        ADDR_FLAGS: flags_nxt = flags_r & ~(pwdata[7:0] & FLAG_WMASK);
        ADDR_PINSEL: pinsel_nxt = pwdata[2:0];
        ADDR_STAT: stat_nxt = stat_r & ~pwdata[7:0];
        ADDR_MASK: mask_nxt = pwdata[7:0];
        default: ;
      endcase
    end
    // hardware set wins over a same-cycle clear
    flags_nxt = flags_nxt | set_flags;
    gated_first = first_r[FIRST_EXT] & flags_r[0];
    gated_periph = ctrl_r[CTRL_GATE] & (
      (pen_one_r[ONE_OSC] & flags_r[1]) | (pen_one_r[ONE_CSW] & flags_r[2]) |
      (pen_one_r[ONE_ADC] & flags_r[3]) | (pen_two_r[TWO_ZCD] & flags_r[4]) |
      (pen_two_r[TWO_CMP1] & flags_r[5]) | (pen_two_r[TWO_CMP2] & flags_r[6]));
    vector_nxt = ctrl_r[CTRL_GLOBAL] & (gated_first | gated_periph);
    if (vector_nxt & ~vector_req) begin
      stat_nxt[STAT_VECTOR] = 1'b1;
    end
    irq_nxt = |(stat_nxt & ~mask_nxt);
    pready_nxt = psel & ~penable;
    pslverr_nxt = psel & ~penable & ~hit;
    prdata_nxt = prdata;
    if (rd_acc) begin
      unique case (paddr)
        ADDR_CTRL: prdata_nxt = {24'h0, ctrl_r};
        ADDR_FIRST: prdata_nxt = {24'h0, first_r};
        ADDR_PEN_ONE: prdata_nxt = {24'h0, pen_one_r};
        ADDR_PEN_TWO: prdata_nxt = {24'h0, pen_two_r};
        ADDR_FLAGS: prdata_nxt = {24'h0, flags_r};
        ADDR_PINSEL: prdata_nxt = {29'h0, ext_irq_pin_select_r};
        ADDR_STAT: prdata_nxt = {24'h0, stat_r};
        ADDR_MASK: prdata_nxt = {24'h0, mask_r};
        default: prdata_nxt = ZERO_WORD;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= REG_RESET;
      first_r <= REG_RESET;
      pen_one_r <= REG_RESET;
      pen_two_r <= REG_RESET;
      flags_r <= REG_RESET;
      ext_irq_pin_select_r <= PINSEL_RESET;
      stat_r <= REG_RESET;
      mask_r <= REG_RESET;
      prdata <= ZERO_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
      vector_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      first_r <= first_nxt;
      pen_one_r <= pen_one_nxt;
      pen_two_r <= pen_two_nxt;
      flags_r <= flags_nxt;
      ext_irq_pin_select_r <= pinsel_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      vector_req <= vector_nxt;
      irq <= irq_nxt;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_GATE_BLOCKS: assert property (
    !ctrl_r[CTRL_GATE] && !(first_r[FIRST_EXT] && flags_r[0]) |=> !vector_req)
    else $error("peripheral vector without gate");
  AST_FIRST_BYPASS: assert property (
    ctrl_r[CTRL_GLOBAL] && first_r[FIRST_EXT] && flags_r[0] |=> vector_req)
    else $error("first-level source did not vector");
  AST_ADC_WRITE: assert property (
    wr_acc && paddr == ADDR_PEN_ONE |=> pen_one_r[ONE_ADC] == $past(pwdata[0]))
    else $error("adc enable not written");
  AST_PIN_SEL: assert property (
    pin_s2_r[ext_irq_pin_select_r] && !$past(pin_s2_r[ext_irq_pin_select_r]) |=> flags_r[0])
    else $error("selected pin edge did not set flag");
  AST_OSC_BITS: assert property (
    wr_acc && paddr == ADDR_PEN_ONE |=> pen_one_r[7:6] == $past(pwdata[7:6]) && pen_one_r[5:1] == 5'h00)
    else $error("osc or clock switch enable wrong");
  AST_CMP_WRITE: assert property (
    wr_acc && paddr == ADDR_PEN_TWO |=> pen_two_r[TWO_CMP1] == $past(pwdata[0]))
    else $error("comparator enable not written");
  AST_VECTOR: assert property (
    ctrl_r[CTRL_GLOBAL] && ctrl_r[CTRL_GATE] && pen_one_r[ONE_ADC] && flags_r[3] |=> vector_req)
    else $error("adc did not vector");
  AST_NO_GLOBAL: assert property (
    !ctrl_r[CTRL_GLOBAL] |=> !vector_req)
    else $error("vector without global enable");
  COV_VEC: cover property (vector_req && ctrl_r[CTRL_GATE]);
  COV_FIRST: cover property (vector_req && !ctrl_r[CTRL_GATE]);
  AST_FLAG_SET: assert property (
    periph_src.adc |=> flags_r[3])
    else $error("adc event did not set its flag");
  AST_RESERVED: assert property (
    pen_one_r[5:1] == 5'h00 && pen_two_r[7] == 1'b0 && pen_two_r[5:2] == 4'h0)
    else $error("unimplemented enable bit set");
  // a set mask bit holds its status bit back from irq
  AST_IRQ_MASK: assert property (
    irq == |(stat_r & ~mask_r))
    else $error("irq does not follow unmasked status");
  AST_BAD_ADDR: assert property (
    psel && !penable && !hit |=> pready && pslverr)
    else $error("unmapped address not refused");

  COV_IRQ: cover property (irq);
  COV_EXT_EDGE: cover property (ext_rise);
  COV_MASKED: cover property (stat_r[STAT_VECTOR] && mask_r[STAT_VECTOR]);
endmodule

// ===== logic/irq_bank_pkg.sv
// constants and types for the peripheral interrupt enable bank
package irq_bank_pkg;
  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_FIRST = 12'h004;
  localparam logic [11:0] ADDR_PEN_ONE = 12'h008;
  localparam logic [11:0] ADDR_PEN_TWO = 12'h00C;
  localparam logic [11:0] ADDR_FLAGS = 12'h010;
  localparam logic [11:0] ADDR_PINSEL = 12'h014;
  localparam logic [11:0] ADDR_STAT = 12'h018;
  localparam logic [11:0] ADDR_MASK = 12'h01C;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_GLOBAL = 7;
  localparam int CTRL_GATE = 6;
  localparam int FIRST_EXT = 0;
  localparam int ONE_OSC = 7;
  localparam int ONE_CSW = 6;
  localparam int ONE_ADC = 0;
  localparam int TWO_ZCD = 6;
  localparam int TWO_CMP2 = 1;
  localparam int TWO_CMP1 = 0;
  localparam int NUM_PINS = 8;
  localparam int STAT_VECTOR = 0;
  // ----------------------------------------
  // write masks and reset values
  // ----------------------------------------
  localparam logic [7:0] CTRL_WMASK = 8'hC0;
  localparam logic [7:0] FIRST_WMASK = 8'h01;
  localparam logic [7:0] ONE_WMASK = 8'hC1;
  localparam logic [7:0] TWO_WMASK = 8'h43;
  localparam logic [7:0] FLAG_WMASK = 8'hFF;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] PINSEL_RESET = 3'h0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // flags: [0] ext pin, [1] osc fail, [2] clock switch, [3] adc,
  // [4] zero cross, [5] comparator one, [6] comparator two
  typedef struct packed {
    logic osc_fail;
    logic clk_switch;
    logic adc;
    logic zero_cross;
    logic cmp_one;
    logic cmp_two;
  } periph_src_t;
endpackage

// ===== verification/src_model.sv
// pulse model of the peripheral event sources
`timescale 1ns/1ps
module src_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requests from the bench
  input wire logic [5:0] fire,
  // source outputs
  output irq_bank_pkg::periph_src_t periph_src
);
  import irq_bank_pkg::*;
  // ----------------------------------------
  // one cycle events
  // ----------------------------------------
  // real sources pulse once, so a held level would hide a missed w1c clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) periph_src <= '0;
    else periph_src <= periph_src_t'(fire);
  end
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the interrupt enable bank
`timescale 1ns/1ps
module tb_top;
  import irq_bank_pkg::*;
  // ----------------------------------------
  // signals, tables and helpers
  // ----------------------------------------
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000, ra;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, vector_req, irq, e;
  logic [5:0] fire = 6'h00;
  logic [7:0] ext_pins = 8'h00;
  periph_src_t periph_src;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  typedef struct {logic [11:0] a; logic [31:0] x;} row_t;
  row_t rows[5] = '{'{ADDR_CTRL, 32'hC0}, '{ADDR_FIRST, 32'h01},
    '{ADDR_PEN_ONE, 32'hC1}, '{ADDR_PEN_TWO, 32'h43}, '{ADDR_PINSEL, 32'h07}};
  // enables in order osc, clock switch, adc, zero cross, cmp one, cmp two
  logic [7:0] en[6] = '{8'h80, 8'h40, 8'h01, 8'h40, 8'h01, 8'h02};

  src_model src (.pclk(pclk), .presetn(presetn), .fire(fire), .periph_src(periph_src));
  peripheral_irq_enable_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_src(periph_src),
    .ext_pins(ext_pins), .vector_req(vector_req), .irq(irq));

  always #5 pclk = ~pclk;
  // a hung handshake ends the run here
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", n, x, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] x);
    apb(0, a, 32'h0);
    chk("read", q, x);
  endtask
  task settle;
    repeat (6) @(posedge pclk);
    #1;
  endtask
  task vec(input logic x);
    settle();
    chk("vector_req", {31'h0, vector_req}, {31'h0, x});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    foreach (rows[i]) begin
      rd_chk(rows[i].a, 32'h0);
      apb(1, rows[i].a, 32'hFFFF_FFFF);
      rd_chk(rows[i].a, rows[i].x);
      apb(1, rows[i].a, 32'h0);
      rd_chk(rows[i].a, 32'h0);
    end
    // unmapped place: refused and reads zero
    apb(1, 12'h020, 32'hFF);
    rd_chk(12'h020, 32'h0);
    chk("pslverr", {31'h0, e}, 32'h1);
    // every peripheral source is held back by the gate, then by its own enable
    for (int j = 0; j < 6; j++) begin
      ra = (j < 3) ? ADDR_PEN_ONE : ADDR_PEN_TWO;
      apb(1, ADDR_CTRL, 32'h80);
      apb(1, ra, {24'h0, en[j]});
      apb(1, ADDR_FLAGS, 32'hFF);
      @(posedge pclk);
      fire <= 6'h20 >> j;
      @(posedge pclk);
      fire <= 6'h00;
      rd_chk(ADDR_FLAGS, 32'h2 << j);
      vec(0);
      apb(1, ADDR_CTRL, 32'hC0);
      vec(1);
      apb(1, ra, 32'h0);
      vec(0);
    end
    // external pin bypasses the gate; only the selected pin counts
    apb(1, ADDR_PINSEL, 32'h5);
    apb(1, ADDR_FIRST, 32'h1);
    apb(1, ADDR_CTRL, 32'h80);
    apb(1, ADDR_FLAGS, 32'hFF);
    apb(1, ADDR_STAT, 32'hFF);
    ext_pins <= 8'h04;
    vec(0);
    @(posedge pclk);
    ext_pins <= 8'h24;
    vec(1);
    rd_chk(ADDR_STAT, 32'h1);
    chk("pslverr mapped", {31'h0, e}, 32'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1, ADDR_MASK, 32'h1);
    settle();
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1, ADDR_MASK, 32'h0);
    settle();
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    apb(1, ADDR_STAT, 32'h1);
    settle();
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1, ADDR_CTRL, 32'h40);
    vec(0);
    // a reset in mid-run clears ctrl, first-level enable, pin select, vector_req and irq
    apb(1, ADDR_CTRL, 32'hC0);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    #1;
    chk("vector_req reset", {31'h0, vector_req}, 32'h0);
    chk("irq reset", {31'h0, irq}, 32'h0);
    rd_chk(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_FIRST, 32'h0);
    rd_chk(ADDR_PINSEL, 32'h0);
    stop_test();
  end
endmodule
